//--- hw/dcte_pkg.sv
`default_nettype none
package dcte_pkg;
   // bus and field widths
   localparam int ADDR_W  = 16;
   localparam int DATA_W  = 16;
   localparam int TSEL_W  = 4;
   localparam int WB_AW   = 8;
   // register map, byte addresses
   localparam logic [7:0] REG_GLOBAL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] CH_BASE    = 8'h20;
   localparam logic [1:0] CH_CTL     = 2'h0;
   localparam logic [1:0] CH_SRC     = 2'h1;
   localparam logic [1:0] CH_DST     = 2'h2;
   localparam logic [1:0] CH_CNT     = 2'h3;
   localparam int         GLB_NMI_BIT = 0;
   // address step encodings
   localparam logic [1:0] STEP_DEC = 2'h2;
   localparam logic [1:0] STEP_INC = 2'h3;
   // transfer modes
   localparam logic [2:0] MODE_SINGLE     = 3'h0;
   localparam logic [2:0] MODE_BLOCK      = 3'h1;
   localparam logic [2:0] MODE_BURST      = 3'h2;
   localparam logic [2:0] MODE_REP_SINGLE = 3'h4;
   localparam logic [2:0] MODE_REP_BLOCK  = 3'h5;
   localparam logic [2:0] MODE_REP_BURST  = 3'h6;
   // burst interleave timing in moves and cycles
   localparam logic [1:0] BURST_RUN = 2'h3; // last of four moves
   localparam logic [1:0] BURST_GAP = 2'h1; // last of two free cycles
   localparam logic [TSEL_W-1:0] EXT_TRIG_SEL = 4'h0;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   // channel control word
   typedef struct packed {
      logic              reserved;
      logic [TSEL_W-1:0] triggerSourceSel;
      logic              triggerLevelSel;
      logic              channelArm;
      logic              srcWidthSel;   // 1 = byte
      logic              dstWidthSel;   // 1 = byte
      logic [1:0]        srcAddrStepSel;
      logic [1:0]        dstAddrStepSel;
      logic [2:0]        transferModeSel;
   } dcte_ctl_type;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SYNC  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b011,
      ST_WAIT  = 3'b100,
      ST_GAP   = 3'b101,
      ST_HOLD  = 3'b110
   } dcte_state_type;
endpackage
`default_nettype wire

//--- hw/dcte_core.sv
`timescale 1ns/1ps
`default_nettype none
module dcte_core
   import dcte_pkg::*;
#(
   parameter int NUM_CH = 3
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rstn,
   // wishbone register slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [WB_AW-1:0]     wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // triggers and abort
   input  wire logic                 externalTriggerIn,
   input  wire logic [14:0]          periphTriggerIn,
   input  wire logic                 nmiIn,
   // system memory bus
   output logic      [ADDR_W-1:0]    memAddr,
   output logic                      memRd,
   output logic                      memWr,
   output logic      [1:0]           memBe,
   output logic      [DATA_W-1:0]    memWdata,
   input  wire logic [DATA_W-1:0]    memRdata,
   output logic                      cpuHalt
);
   localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

   dcte_ctl_type         ctl       [NUM_CH];
   logic [ADDR_W-1:0]    srcPtr    [NUM_CH];
   logic [ADDR_W-1:0]    dstPtr    [NUM_CH];
   logic [15:0]          cnt       [NUM_CH];
   logic [ADDR_W-1:0]    tSrc      [NUM_CH];
   logic [ADDR_W-1:0]    tDst      [NUM_CH];
   logic [15:0]          cntTemp   [NUM_CH];
   logic [NUM_CH-1:0]    loaded;
   logic [NUM_CH-1:0]    doneFlag;
   logic [NUM_CH-1:0]    pending;
   logic [NUM_CH-1:0]    trigPrev;
   logic [NUM_CH-1:0]    selTrig;
   logic [NUM_CH-1:0]    levelMode;
   logic [NUM_CH-1:0]    req;
   logic                 nmiAbortEn;
   dcte_state_type       state;
   dcte_state_type       next_state;
   logic [CH_W-1:0]      curCh;
   logic [CH_W-1:0]      pickCh;
   logic [1:0]           burstCnt;
   logic [1:0]           gapCnt;
   logic [TSEL_W**2-1:0] trigVec;
   dcte_ctl_type         curCtl;
   logic [ADDR_W-1:0]    curSrc;
   logic [ADDR_W-1:0]    curDst;
   logic [15:0]          curCnt;
   logic                 curTrig;
   logic                 loadNow;
   logic                 endNow;
   logic                 abortNow;
   logic                 wbWr;
   logic [7:0]           chOff;
   logic [3:0]           chSel;
   logic                 chHit;
   logic [ADDR_W-1:0]    readAddr;
   logic [7:0]           src_width_sel;

   // step a pointer by its own access width
   function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a, input logic [1:0] sel,
                                                   input logic byteW);
      logic [ADDR_W-1:0] delta;
      delta = byteW ? 16'h0001 : 16'h0002;
      case (sel)
         STEP_INC: stepAddr = a + delta;
         STEP_DEC: stepAddr = a - delta;
         default:  stepAddr = a;
      endcase
   endfunction

   // merge a 16-bit register with the low two byte lanes
   function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] sel);
      laneMerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   // current channel views
   assign curCtl   = ctl[curCh];
   assign curSrc   = tSrc[curCh];
   assign curDst   = tDst[curCh];
   assign curCnt   = cnt[curCh];
   assign curTrig  = selTrig[curCh];
   assign trigVec  = {periphTriggerIn, externalTriggerIn};
   assign loadNow  = (state == ST_SYNC) && !loaded[curCh];
   assign endNow   = (state == ST_WAIT) && (curCnt == 16'h0000);
   // a move already on the bus always completes before an abort
   assign abortNow = nmiIn && nmiAbortEn && (state inside {ST_SYNC, ST_WAIT, ST_GAP, ST_HOLD});
   assign cpuHalt  = state inside {ST_SYNC, ST_READ, ST_WRITE, ST_WAIT};
   assign readAddr = loadNow ? srcPtr[curCh] : curSrc;

   // register decode
   assign chOff = wb_adr_i - CH_BASE;
   assign chSel = chOff[7:4];
   assign chHit = (wb_adr_i >= CH_BASE) && (chOff < 8'(NUM_CH * 16));
   assign wbWr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   // per-channel trigger selection and request
   for (genvar c = 0; c < NUM_CH; c++) begin : g_trig
      assign selTrig[c]   = trigVec[ctl[c].triggerSourceSel];
      // level sensing only honoured on the external input
      assign levelMode[c] = ctl[c].triggerLevelSel && (ctl[c].triggerSourceSel == EXT_TRIG_SEL);
      // zero count never requests a move
      assign req[c] = ctl[c].channelArm && (cnt[c] != 16'h0000) &&
                      (levelMode[c] ? selTrig[c] : pending[c]);
   end

   // edge detect; an event before arming leaves no pending request
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         trigPrev <= '0;
         pending  <= '0;
      end else begin
         trigPrev <= selTrig;
         for (int c = 0; c < NUM_CH; c++) begin
            // edges during an own block or burst are dropped, single mode keeps them
            if (selTrig[c] && !trigPrev[c] && ctl[c].channelArm &&
                !(state != ST_IDLE && curCh == CH_W'(c) &&
                  (ctl[c].transferModeSel[1] || ctl[c].transferModeSel[0]))) begin
               pending[c] <= 1'b1;
            end else if ((state == ST_SYNC && curCh == CH_W'(c)) || !ctl[c].channelArm) begin
               pending[c] <= 1'b0;
            end
         end
      end
   end

   // fixed priority, channel zero wins
   always_comb begin
      pickCh = '0;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (req[c]) begin
            pickCh = CH_W'(c);
         end
      end
   end

   // transfer sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (|req) begin
               next_state = ST_SYNC;
            end
         end
         ST_SYNC:  next_state = ST_READ;
         ST_READ:  next_state = ST_WRITE;
         ST_WRITE: next_state = ST_WAIT;
         ST_WAIT: begin
            if (curCnt == 16'h0000) begin
               // repeated burst starts over with no trigger
               next_state = (curCtl.transferModeSel[2] && curCtl.transferModeSel[1] && curCtl.channelArm)
                            ? ST_SYNC : ST_IDLE;
            end else if (!(curCtl.transferModeSel[1] || curCtl.transferModeSel[0])) begin
               next_state = ST_IDLE;
            end else if (curCtl.transferModeSel[1] && !curCtl.channelArm) begin
               next_state = ST_IDLE;
            end else if (levelMode[curCh] && !curTrig) begin
               next_state = ST_HOLD;
            end else if (curCtl.transferModeSel[1] && burstCnt == BURST_RUN) begin
               next_state = ST_GAP;
            end else begin
               next_state = ST_READ;
            end
         end
         ST_GAP: begin
            if (!curCtl.channelArm) begin
               next_state = ST_IDLE;
            end else if (gapCnt == BURST_GAP) begin
               next_state = ST_READ;
            end
         end
         ST_HOLD: begin
            // a register rewrite drops the frozen block
            if (!loaded[curCh]) begin
               next_state = ST_IDLE;
            end else if (curTrig) begin
               next_state = ST_READ;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (abortNow) begin
         next_state = ST_IDLE;
      end
   end

   // state, channel and interleave counters
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state    <= ST_IDLE;
         curCh    <= '0;
         burstCnt <= 2'h0;
         gapCnt   <= 2'h0;
      end else begin
         state <= next_state;
         if (state == ST_IDLE) begin
            curCh <= pickCh;
         end
         if (state == ST_SYNC) begin
            burstCnt <= 2'h0;
         end else if (state == ST_WAIT) begin
            burstCnt <= burstCnt + 2'h1;
         end
         gapCnt <= (state == ST_GAP) ? gapCnt + 2'h1 : 2'h0;
      end
   end

   // working copies taken at start, stepped after each move
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         for (int c = 0; c < NUM_CH; c++) begin
            tSrc[c]    <= '0;
            tDst[c]    <= '0;
            cntTemp[c] <= 16'h0000;
         end
      end else if (loadNow) begin
         tSrc[curCh]    <= srcPtr[curCh];
         tDst[curCh]    <= dstPtr[curCh];
         cntTemp[curCh] <= curCnt;
      end else if (state == ST_WRITE) begin
         tSrc[curCh] <= stepAddr(curSrc, curCtl.srcAddrStepSel, curCtl.srcWidthSel);
         tDst[curCh] <= stepAddr(curDst, curCtl.dstAddrStepSel, curCtl.dstWidthSel);
      end
   end

   // byte picked from the source lane
   assign src_width_sel = (curCtl.srcWidthSel && curSrc[0]) ? memRdata[15:8] : memRdata[7:0];

   // memory bus: read cycle, write cycle, then the wait cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         memAddr  <= '0;
         memRd    <= 1'b0;
         memWr    <= 1'b0;
         memBe    <= 2'h0;
         memWdata <= '0;
      end else begin
         memRd <= 1'b0;
         memWr <= 1'b0;
         if (next_state == ST_READ) begin
            memRd   <= 1'b1;
            memAddr <= readAddr;
            memBe   <= curCtl.srcWidthSel ? (readAddr[0] ? 2'h2 : 2'h1) : 2'h3;
         end
         if (state == ST_READ) begin
            memWr   <= 1'b1;
            memAddr <= curDst;
            if (curCtl.dstWidthSel) begin
               memWdata <= {src_width_sel, src_width_sel};
               memBe    <= curDst[0] ? 2'h2 : 2'h1;
            end else begin
               memWdata <= curCtl.srcWidthSel ? {8'h00, src_width_sel} : memRdata;
               memBe    <= 2'h3;
            end
         end
      end
   end

   // channel registers; a software write in the same cycle beats the engine
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         for (int c = 0; c < NUM_CH; c++) begin
            ctl[c]    <= CTL_RESET;
            srcPtr[c] <= '0;
            dstPtr[c] <= '0;
            cnt[c]    <= 16'h0000;
         end
         loaded <= '0;
      end else begin
         if (loadNow) begin
            loaded[curCh] <= 1'b1;
         end
         if (state == ST_WRITE) begin
            cnt[curCh] <= curCnt - 16'h0001;
         end
         if (endNow) begin
            cnt[curCh]    <= cntTemp[curCh];
            loaded[curCh] <= 1'b0;
            if (!curCtl.transferModeSel[2]) begin
               ctl[curCh].channelArm <= 1'b0;
            end
         end
         if (abortNow) begin
            ctl[curCh].channelArm <= 1'b0;
         end
         for (int c = 0; c < NUM_CH; c++) begin
            if (wbWr && chHit && chSel == 4'(c)) begin
               loaded[c] <= 1'b0;
               case (wb_adr_i[3:2])
                  CH_CTL:  ctl[c]    <= laneMerge(ctl[c], wb_dat_i, wb_sel_i);
                  CH_SRC:  srcPtr[c] <= laneMerge(srcPtr[c], wb_dat_i, wb_sel_i);
                  CH_DST:  dstPtr[c] <= laneMerge(dstPtr[c], wb_dat_i, wb_sel_i);
                  default: cnt[c]    <= laneMerge(cnt[c], wb_dat_i, wb_sel_i);
               endcase
            end
         end
      end
   end

   // global control and done flags; hardware set wins over write-one-to-clear
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         nmiAbortEn <= 1'b0;
         doneFlag   <= '0;
      end else begin
         if (wbWr && wb_adr_i == REG_GLOBAL && wb_sel_i[0]) begin
            nmiAbortEn <= wb_dat_i[GLB_NMI_BIT];
         end
         for (int c = 0; c < NUM_CH; c++) begin
            if (endNow && curCh == CH_W'(c)) begin
               doneFlag[c] <= 1'b1;
            end else if (wbWr && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[c]) begin
               doneFlag[c] <= 1'b0;
            end
         end
      end
   end

   // wishbone answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_adr_i == REG_GLOBAL) begin
            wb_dat_o[GLB_NMI_BIT] <= nmiAbortEn;
         end else if (wb_adr_i == REG_STATUS) begin
            wb_dat_o[NUM_CH-1:0] <= doneFlag;
         end else if (chHit) begin
            case (wb_adr_i[3:2])
               CH_CTL:  wb_dat_o[15:0] <= ctl[chSel[CH_W-1:0]];
               CH_SRC:  wb_dat_o[15:0] <= srcPtr[chSel[CH_W-1:0]];
               CH_DST:  wb_dat_o[15:0] <= dstPtr[chSel[CH_W-1:0]];
               default: wb_dat_o[15:0] <= cnt[chSel[CH_W-1:0]];
            endcase
         end
      end
   end

   // checks
   chk_src_step: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == ST_WRITE && curCtl.srcAddrStepSel == STEP_INC) |=>
      curSrc == $past(curSrc) + ($past(curCtl.srcWidthSel) ? 16'h0001 : 16'h0002))
      else $error("source pointer did not step up");
   chk_dst_step: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == ST_WRITE && curCtl.dstAddrStepSel == STEP_DEC) |=>
      curDst == $past(curDst) - ($past(curCtl.dstWidthSel) ? 16'h0001 : 16'h0002))
      else $error("destination pointer did not step down");
   chk_word_byte: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == ST_READ && curCtl.dstWidthSel && !curCtl.srcWidthSel) |=>
      memWr && memWdata[7:0] == $past(memRdata[7:0]))
      else $error("word to byte did not keep low byte");
   chk_byte_word: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == ST_WRITE && curCtl.srcWidthSel && !curCtl.dstWidthSel) |->
      memWdata[15:8] == 8'h00 && memBe == 2'h3)
      else $error("byte to word upper byte not cleared");
   chk_arm_clear: assert property (@(posedge core_clk) disable iff (!rstn)
      (endNow && !curCtl.transferModeSel[2] && !wbWr) |=> !ctl[$past(curCh)].channelArm)
      else $error("arm not cleared at count end");
   chk_zero_count: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == ST_SYNC) |-> curCnt != 16'h0000)
      else $error("transfer started with zero count");
   chk_done_set: assert property (@(posedge core_clk) disable iff (!rstn)
      endNow |=> doneFlag[$past(curCh)] && cnt[$past(curCh)] == $past(cntTemp[curCh]))
      else $error("count end without reload and done");
   chk_move_timing: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == ST_READ) |-> memRd ##1 (state == ST_WRITE && memWr) ##1 (state == ST_WAIT && !memWr))
      else $error("move did not take read, write, wait");
   chk_burst_gap: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(state == ST_GAP) |-> (!cpuHalt)[*2] ##1 (state != ST_GAP))
      else $error("burst gap not two free cycles");
   chk_halt_move: assert property (@(posedge core_clk) disable iff (!rstn)
      (state == ST_SYNC && !abortNow) |-> cpuHalt ##1 cpuHalt ##1 cpuHalt ##1 cpuHalt)
      else $error("cpu not halted during move");
endmodule
`default_nettype wire

//--- test/dcte_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dcte_mem
   import dcte_pkg::*;
(
   // engine side of the memory bus
   input  wire logic              core_clk,
   input  wire logic [ADDR_W-1:0] memAddr,
   input  wire logic              memRd,
   input  wire logic              memWr,
   input  wire logic [1:0]        memBe,
   input  wire logic [DATA_W-1:0] memWdata,
   output logic      [DATA_W-1:0] memRdata
);
   logic [DATA_W-1:0] ram [0:255];
   logic [DATA_W-1:0] lastRd = 16'h0000;
   // zero-wait read; off a read the bus shows the inverse of the last word so stale data never passes
   assign memRdata = (memRd === 1'b1) ? ram[memAddr[8:1]] : ~lastRd;
   // lanes honoured; only 512 bytes, higher addresses wrap
   always @(posedge core_clk) begin
      if (memRd === 1'b1) lastRd <= ram[memAddr[8:1]];
      if (memWr === 1'b1 && memBe[0]) ram[memAddr[8:1]][7:0] <= memWdata[7:0];
      if (memWr === 1'b1 && memBe[1]) ram[memAddr[8:1]][15:8] <= memWdata[15:8];
   end
endmodule
`default_nettype wire

//--- test/dcte_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module dcte_tb
   import dcte_pkg::*;
;
   logic              core_clk = 1'b0;
   logic              rstn = 1'b0;
   logic              wbCyc = 1'b0;
   logic              wbStb = 1'b0;
   logic              wbWe = 1'b0;
   logic [WB_AW-1:0]  wbAdr = 8'h00;
   logic [31:0]       wbWdat = 32'h0;
   logic [31:0]       wbRdat;
   logic              wbAck;
   logic              extTrig = 1'b0;
   logic              nmi = 1'b0;
   logic [ADDR_W-1:0] memAddr;
   logic              memRd;
   logic              memWr;
   logic [1:0]        memBe;
   logic [DATA_W-1:0] memWdata;
   logic [DATA_W-1:0] memRdata;
   logic              cpuHalt;
   int                mismatches = 0;
   int                nChecks = 0;
   int                nWr = 0;
   int                nLow = 0;
   int                lowFrom = 0;
   int                lowTo = 0;
   logic [15:0]       sh [0:255];
   logic [ADDR_W-1:0] sp;
   logic [ADDR_W-1:0] dp;
   logic [31:0]       q;
   dcte_ctl_type      ctl;

   dcte_core DUT (
      .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbWdat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck),
      .externalTriggerIn(extTrig), .periphTriggerIn(15'h0000), .nmiIn(nmi), .memAddr(memAddr),
      .memRd(memRd), .memWr(memWr), .memBe(memBe), .memWdata(memWdata), .memRdata(memRdata),
      .cpuHalt(cpuHalt)
   );
   dcte_mem mem (
      .core_clk(core_clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memBe(memBe),
      .memWdata(memWdata), .memRdata(memRdata)
   );

   // 40 MHz clock
   initial forever #12.5 core_clk = ~core_clk;
   // write pulses, and cpu-free cycles between first and last move of a block
   always @(posedge core_clk) begin
      if (memWr === 1'b1) nWr++;
      if (cpuHalt === 1'b0 && nWr > lowFrom && nWr < lowTo) nLow++;
   end
   // a hang ends the run through the normal closing path
   initial begin
      repeat (40000) @(posedge core_clk);
      mismatches++;
      end_of_test();
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // classic cycle held until ack is sampled at an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbWdat <= d;
      do begin
         @(posedge core_clk);
         t++;
      end while (wbAck !== 1'b1 && t < 40);
      if (t >= 40) mismatches++;
      q = wbRdat;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge core_clk);
   endtask
   function automatic logic [7:0] ra(input int ch, input logic [1:0] r);
      return CH_BASE + 8'(ch * 16) + {4'h0, r, 2'b00};
   endfunction
   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a, input logic [1:0] s, input logic b);
      if (s == STEP_INC) return a + (b ? 16'h0001 : 16'h0002);
      if (s == STEP_DEC) return a - (b ? 16'h0001 : 16'h0002);
      return a;
   endfunction
   // expected effect of one move on the shadow memory
   task automatic refMove();
      logic [15:0] w;
      logic [7:0]  b;
      w = sh[sp[8:1]];
      b = (ctl.srcWidthSel && sp[0]) ? w[15:8] : w[7:0];
      if (ctl.dstWidthSel && dp[0]) sh[dp[8:1]][15:8] = b;
      else if (ctl.dstWidthSel) sh[dp[8:1]][7:0] = b;
      else sh[dp[8:1]] = ctl.srcWidthSel ? {8'h00, b} : w;
      sp = step(sp, ctl.srcAddrStepSel, ctl.srcWidthSel);
      dp = step(dp, ctl.dstAddrStepSel, ctl.dstWidthSel);
   endtask
   task automatic pulse();
      extTrig <= 1'b1;
      repeat (2) @(posedge core_clk);
      extTrig <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic waitWr(input int target);
      for (int t = 0; t < 400 && nWr < target; t++) @(posedge core_clk);
      repeat (6) @(posedge core_clk);
   endtask
   // fresh memory, then pointers, count and control; arm goes last with the trigger low
   task automatic arm(input int ch, input logic [15:0] n);
      for (int i = 0; i < 256; i++) begin
         sh[i] = 16'($urandom);
         mem.ram[i] = sh[i];
      end
      sp = {15'h0030, ctl.srcWidthSel & 1'($urandom)};
      dp = {15'h0080, ctl.dstWidthSel & 1'($urandom)};
      wb(1'b1, REG_STATUS, 32'h0000_00FF);
      wb(1'b1, ra(ch, CH_SRC), {16'h0, sp});
      wb(1'b1, ra(ch, CH_DST), {16'h0, dp});
      wb(1'b1, ra(ch, CH_CNT), {16'h0, n});
      wb(1'b1, ra(ch, CH_CTL), {16'h0, ctl});
   endtask
   // one mode code with random widths and steps, then a retrigger after the end; codes 6 and 7 get fixed steps and a stop instead
   task automatic runMode(input logic [2:0] m);
      int n;
      int ch;
      int base;
      int e;
      n = (m >= 3'h6) ? 4 : 6;
      ch = m % 3;
      ctl = dcte_ctl_type'(16'($urandom));
      ctl.reserved = 1'b0;
      ctl.triggerSourceSel = EXT_TRIG_SEL;
      ctl.triggerLevelSel = 1'b0;
      ctl.channelArm = 1'b1;
      ctl.transferModeSel = m;
      if (m >= 3'h6) {ctl.srcAddrStepSel, ctl.dstAddrStepSel} = 4'h0;
      wb(1'b1, REG_GLOBAL, {31'h0, m == 3'h7});
      arm(ch, 16'(n));
      base = nWr;
      lowFrom = base;
      lowTo = base + n;
      nLow = 0;
      if (m[1:0] == 2'h0) begin
         for (int k = 1; k <= n; k++) begin
            pulse();
            waitWr(base + k);
         end
      end else begin
         pulse();
         pulse();
         waitWr(base + n + ((m >= 3'h6) ? 1 : 0));
      end
      repeat (n) refMove();
      if (m >= 3'h6) begin
         `CHK("burst restart", 1'b1, 1'(nWr > base + n))
         // clear only the arm bit, so a move already on the bus keeps its widths
         if (m == 3'h6) wb(1'b1, ra(ch, CH_CTL), {16'h0, ctl} & 32'hFFFF_FDFF);
         else begin
            nmi <= 1'b1;
            repeat (4) @(posedge core_clk);
            nmi <= 1'b0;
         end
         repeat (8) @(posedge core_clk);
         base = nWr;
         repeat (20) @(posedge core_clk);
         `CHK("burst stop", base, nWr)
      end else `CHK("writes", base + n, nWr)
      for (int i = 0; i < 256; i++) `CHK("memory", sh[i], mem.ram[i])
      wb(1'b0, ra(ch, CH_CTL), 32'h0);
      `CHK("arm", m[2] && m < 3'h6, q[9])
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK("done", 1'b1, q[ch])
      if (m == 3'h1 || m == 3'h5) `CHK("halt gaps", 0, nLow)
      if (m[2:1] == 2'h1) `CHK("burst gaps", 2, nLow)
      if (m < 3'h6) begin
         wb(1'b0, ra(ch, CH_CNT), 32'h0);
         `CHK("count", 32'(n), q)
         e = (m == 3'h4) ? 1 : ((m == 3'h5) ? n : 0);
         base = nWr;
         pulse();
         waitWr(base + e);
         `CHK("retrigger", base + e, nWr)
      end
      wb(1'b1, ra(ch, CH_CTL), 32'h0);
   endtask

   initial begin
      void'($urandom(32'hBEA9));
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      wb(1'b1, 8'hF0, 32'hFFFF_FFFF);
      for (int a = 0; a < 16; a++) begin
         wb(1'b0, (a < 12) ? ra(a / 4, 2'(a)) : 8'hF0, 32'h0);
         `CHK("reg reset", 32'h0, q)
      end
      sp = 16'($urandom);
      wb(1'b1, ra(1, CH_SRC), {16'hFFFF, sp});
      wb(1'b0, ra(1, CH_SRC), 32'h0);
      `CHK("src readback", {16'h0, sp}, q)
      for (int m = 0; m < 8; m++) runMode(3'(m));
      // zero count never moves anything
      ctl = 16'h0000;
      ctl.channelArm = 1'b1;
      ctl.transferModeSel = MODE_BLOCK;
      arm(0, 16'h0000);
      lowTo = nWr;
      pulse();
      waitWr(lowTo);
      `CHK("zero count", lowTo, nWr)
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK("zero done", 32'h0, q)
      // disarm, so the edge taken at zero count cannot start a block once a count is written
      wb(1'b1, ra(0, CH_CTL), 32'h0);
      // level block: dropping the trigger freezes it, raising resumes
      ctl.triggerLevelSel = 1'b1;
      ctl.srcAddrStepSel = STEP_INC;
      ctl.dstAddrStepSel = STEP_DEC;
      arm(0, 16'h0006);
      lowTo = nWr;
      extTrig <= 1'b1;
      while (nWr < lowTo + 2) @(posedge core_clk);
      extTrig <= 1'b0;
      repeat (8) @(posedge core_clk);
      lowFrom = nWr;
      repeat (16) @(posedge core_clk);
      `CHK("level freeze", lowFrom, nWr)
      `CHK("level held", 1'b1, 1'(lowFrom < lowTo + 6))
      extTrig <= 1'b1;
      waitWr(lowTo + 6);
      extTrig <= 1'b0;
      `CHK("level writes", lowTo + 6, nWr)
      repeat (6) refMove();
      for (int i = 0; i < 256; i++) `CHK("level memory", sh[i], mem.ram[i])
      end_of_test();
   end
endmodule
`undef CHK
`default_nettype wire
